// File: supply_integrity_monitor.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "supply_integrity_regs.svh"
module supply_integrity_monitor
   import supply_integrity_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output reg_byte_t reg_rdata,
   input wire logic drop_cmp_below,
   input wire logic warn_cmp_below,
   input wire logic opt_detector_enable,
   input wire logic [1:0] opt_threshold_sel,
   output logic [1:0] threshold_sel,
   input wire logic wdg_underflow,
   output logic wdg_flag_clear,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic sys_reset_n,
   input wire logic pll_locked,
   input wire logic global_irq_mask,
   input wire logic irq_ack,
   input wire logic wait_mode,
   input wire logic halt_mode,
   output logic irq_req,
   output logic wake_from_wait
);

   ////////////////////////////////////////////////////////////////////////////
   // synchronised comparator and pin inputs

   logic [2:0] sync_q;
   logic drop_sync;
   logic warn_sync;
   logic pin_sync;

   sync_two_stage #(
      .WIDTH(3)
   ) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in({reset_pin_in, warn_cmp_below, drop_cmp_below}),
      .sync_out(sync_q)
   );

   assign drop_sync = sync_q[0];
   assign warn_sync = sync_q[1];
   // pin reads high when idle; a low level means someone pulls it
   assign pin_sync = sync_q[2];

   ////////////////////////////////////////////////////////////////////////////
   // option capture, only while the device sits in reset

   logic opt_en;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         opt_en <= 1'b0;
         threshold_sel <= 2'b00;
      end
      else if (!sys_reset_n)
      begin
         // options never change under running software
         opt_en <= opt_detector_enable;
         threshold_sel <= opt_threshold_sel;
      end
   end

   logic drop_src;
   logic warn_level;

   assign drop_src = opt_en & drop_sync;
   assign warn_level = opt_en & warn_sync;

   ////////////////////////////////////////////////////////////////////////////
   // reset sequencer

   seq_state_e state;
   seq_state_e next_state;
   logic [7:0] delay_cnt;
   logic [4:0] wdg_cnt;
   logic [1:0] guard_cnt;
   logic ext_src;
   logic delay_done;

   // readback of our own drive lingers through the synchroniser
   assign ext_src = !pin_sync && state == SEQ_RUN && guard_cnt == 2'd0;
   assign delay_done = delay_cnt == 8'(`SI_RESET_DELAY_CYC - 1);

   always_comb
   begin
      next_state = state;
      unique case (state)
         SEQ_RUN:
         begin
            if (drop_src || wdg_underflow || ext_src)
            begin
               next_state = SEQ_HOLD;
            end
         end
         SEQ_HOLD:
         begin
            if (!drop_src && wdg_cnt == 5'd0 && !wdg_underflow)
            begin
               next_state = SEQ_DELAY;
            end
         end
         SEQ_DELAY:
         begin
            if (drop_src || wdg_underflow)
            begin
               next_state = SEQ_HOLD;
            end
            else if (delay_done)
            begin
               next_state = SEQ_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state <= SEQ_HOLD;
      end
      else
      begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n || state != SEQ_DELAY)
      begin
         delay_cnt <= 8'h00;
      end
      else
      begin
         delay_cnt <= delay_cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wdg_cnt <= 5'h00;
      end
      else if (wdg_underflow)
      begin
         wdg_cnt <= 5'(`SI_WDG_PULSE_CYC - 1);
      end
      else if (wdg_cnt != 5'h00)
      begin
         wdg_cnt <= wdg_cnt - 5'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         guard_cnt <= 2'h0;
      end
      else if (state == SEQ_DELAY && next_state == SEQ_RUN)
      begin
         guard_cnt <= 2'(`SI_RELEASE_GUARD_CYC);
      end
      else if (guard_cnt != 2'h0)
      begin
         guard_cnt <= guard_cnt - 2'h1;
      end
   end

   // open drain: the pin only ever pulls low
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = state != SEQ_RUN;
   assign sys_reset_n = state == SEQ_RUN;

   ////////////////////////////////////////////////////////////////////////////
   // status and control register

   logic dev_reset;
   logic csr_wr;
   logic irq_enable;
   logic warn_flag;
   logic drop_flag;
   logic drop_prev;
   logic irq_pending;
   logic warn_change;
   localparam reg_byte_t csr_reset_val = `SI_CSR_RESET;

   assign dev_reset = !rst_n || !sys_reset_n;
   // halt freezes the register against software and warn_flag against hardware; drop_flag still sets
   assign csr_wr = reg_wr && reg_addr == `SI_CSR_ADDR && !halt_mode;
   assign warn_change = !halt_mode && warn_level != warn_flag;

   always_ff @(posedge mclk)
   begin
      if (dev_reset)
      begin
         irq_enable <= csr_reset_val[`SI_BIT_IRQ_ENABLE];
      end
      else if (csr_wr)
      begin
         irq_enable <= reg_wdata[`SI_BIT_IRQ_ENABLE];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (dev_reset)
      begin
         warn_flag <= csr_reset_val[`SI_BIT_WARN_FLAG];
      end
      else if (!halt_mode)
      begin
         warn_flag <= warn_level;
      end
   end

   // only power-on or a CSR write of 0 clears it; sequencer resets keep the cause
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         drop_flag <= 1'b0;
      end
      else if (drop_src)
      begin
         drop_flag <= 1'b1;
      end
      else if (csr_wr && !reg_wdata[`SI_BIT_DROP_FLAG])
      begin
         drop_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         drop_prev <= 1'b0;
         wdg_flag_clear <= 1'b0;
      end
      else
      begin
         drop_prev <= drop_src;
         wdg_flag_clear <= drop_src && !drop_prev;
      end
   end

   // a flag change in the acknowledge cycle survives
   always_ff @(posedge mclk)
   begin
      if (dev_reset)
      begin
         irq_pending <= 1'b0;
      end
      else if (warn_change && irq_enable)
      begin
         irq_pending <= 1'b1;
      end
      else if (irq_ack)
      begin
         irq_pending <= 1'b0;
      end
   end

   assign irq_req = irq_pending && irq_enable && !global_irq_mask;
   assign wake_from_wait = irq_pending && irq_enable && wait_mode && !halt_mode;

   always_ff @(posedge mclk)
   begin
      if (!rst_n || !reg_rd)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_addr == `SI_CSR_ADDR)
      begin
         // upper nibble always reads zero
         reg_rdata <= {4'h0, pll_locked, drop_flag, warn_flag, irq_enable};
      end
      else
      begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_drop_seen;
      drop_src && sys_reset_n;
   endsequence

   sequence s_pin_held;
      reset_pin_oe [*8];
   endsequence

   chk_drop_pin_low: assert property (s_drop_seen |=> s_pin_held)
      else $error("supply drop did not hold reset pin low");

   chk_wdg_pulse: assert property (wdg_underflow |=> reset_pin_oe [*8] ##12 reset_pin_oe)
      else $error("watchdog pulse on reset pin too short");

   chk_static_reset: assert property (drop_src |=> !sys_reset_n)
      else $error("device left reset while supply low");

   chk_disabled_silent: assert property
      (!opt_en && !drop_flag && !halt_mode |=> !drop_flag && !warn_flag && !wdg_flag_clear)
      else $error("disabled detector still active");

   chk_drop_clears_wdg: assert property ($rose(drop_src) |=> wdg_flag_clear)
      else $error("watchdog flag not cleared on drop");

   chk_drop_flag_set: assert property (drop_src |=> drop_flag)
      else $error("drop flag not set");

   chk_irq_on_change: assert property
      (sys_reset_n && irq_enable && warn_change && !halt_mode ##1 sys_reset_n |-> irq_pending)
      else $error("warning change raised no interrupt");

   chk_irq_gating: assert property (irq_req |-> irq_enable && !global_irq_mask)
      else $error("interrupt delivered while gated");

   chk_ack_clear: assert property
      (irq_pending && irq_ack && !(warn_change && irq_enable) |=> !irq_pending)
      else $error("service entry did not clear pending");

   chk_halt_freeze: assert property
      (halt_mode && sys_reset_n ##1 sys_reset_n |-> $stable(irq_enable) && $stable(warn_flag))
      else $error("register changed in halt");

   chk_release_delay: assert property
      ($rose(sys_reset_n) |-> $past(state == SEQ_DELAY, 256) && $past(reset_pin_oe, 256))
      else $error("reset released before 256 cycles");

   chk_read_zero_top: assert property (reg_rd |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");

endmodule

// File: supply_integrity_regs.svh
`ifndef SUPPLY_INTEGRITY_REGS_SVH
`define SUPPLY_INTEGRITY_REGS_SVH

`define SI_CSR_ADDR 8'h3a
`define SI_CSR_RESET 8'h00
`define SI_BIT_IRQ_ENABLE 0
`define SI_BIT_WARN_FLAG 1
`define SI_BIT_DROP_FLAG 2
`define SI_BIT_LOCKED 3

`define SI_CLK_PERIOD_NS 25
`define SI_WDG_PULSE_NS 500
`define SI_WDG_PULSE_CYC ((`SI_WDG_PULSE_NS + `SI_CLK_PERIOD_NS - 1) / `SI_CLK_PERIOD_NS)
`define SI_RESET_DELAY_CYC 256
`define SI_RELEASE_GUARD_CYC 3

`endif

// File: supply_integrity_pkg.sv
package supply_integrity_pkg;

   // one-bit steps run -> hold -> delay; delay -> run flips both bits
   typedef enum logic [1:0]
   {
      SEQ_RUN = 2'b00,
      SEQ_HOLD = 2'b01,
      SEQ_DELAY = 2'b11
   } seq_state_e;

   typedef logic [7:0] reg_byte_t;

endpackage

// File: sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
   parameter int WIDTH = 3
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         logic meta;
         always_ff @(posedge mclk)
         begin
            if (!rst_n)
            begin
               meta <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta <= async_in[i];
               sync_out[i] <= meta;
            end
         end
      end
   endgenerate

endmodule

// File: reset_line_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// another chip on the shared open-drain reset line
module reset_line_partner
(
   input wire logic mclk,
   input wire logic line_level,
   input wire logic pull_req,
   output logic ext_oe,
   output int low_cycles
);
   // only ever pulls low; the line's pull-up gives the high level
   assign ext_oe = pull_req;

   initial low_cycles = 0;

   // counts cycles this chip is held in reset by someone else
   always @(posedge mclk)
   begin
      if (line_level === 1'b0 && !pull_req)
         low_cycles <= low_cycles + 1;
   end
endmodule

// File: supply_integrity_monitor_bench.sv
`timescale 1ns/1ps
`include "supply_integrity_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module supply_integrity_monitor_bench
   import supply_integrity_pkg::*;
;
   logic mclk = 0;
   logic rst_n = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 0;
   logic reg_rd = 0;
   reg_byte_t reg_rdata;
   logic drop_cmp_below = 0;
   logic warn_cmp_below = 0;
   logic opt_detector_enable = 1;
   logic [1:0] opt_threshold_sel = 2'b01;
   logic [1:0] threshold_sel;
   logic wdg_underflow = 0;
   logic wdg_flag_clear, reset_pin_in, reset_pin_out, reset_pin_oe, sys_reset_n;
   logic pll_locked = 1;
   logic global_irq_mask = 0;
   logic irq_ack = 0;
   logic wait_mode = 0;
   logic halt_mode = 0;
   logic irq_req, wake_from_wait, ext_pull, ext_oe, clr_seen;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   int low_cycles;
   int n;
   reg_byte_t rd;

   ////////////////////////////////////////////////////////////////////////////////
   always #12.5 mclk = ~mclk;

   // wired-and line with pull-up
   assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || ext_oe);

   supply_integrity_monitor u_supply_integrity_monitor (.mclk(mclk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .drop_cmp_below(drop_cmp_below),
      .warn_cmp_below(warn_cmp_below), .opt_detector_enable(opt_detector_enable),
      .opt_threshold_sel(opt_threshold_sel), .threshold_sel(threshold_sel),
      .wdg_underflow(wdg_underflow), .wdg_flag_clear(wdg_flag_clear),
      .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
      .reset_pin_oe(reset_pin_oe), .sys_reset_n(sys_reset_n), .pll_locked(pll_locked),
      .global_irq_mask(global_irq_mask), .irq_ack(irq_ack), .wait_mode(wait_mode),
      .halt_mode(halt_mode), .irq_req(irq_req), .wake_from_wait(wake_from_wait));

   reset_line_partner u_reset_line_partner (.mclk(mclk), .line_level(reset_pin_in),
      .pull_req(ext_pull), .ext_oe(ext_oe), .low_cycles(low_cycles));

   initial ext_pull = 0;
   initial clr_seen = 0;

   always @(posedge mclk)
   begin
      if (wdg_flag_clear === 1'b1)
         clr_seen <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // whole run needs about 1750 cycles; generous ceiling
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdreg(input logic [7:0] a, output reg_byte_t d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // counts pin-driven cycles until internal reset lifts, bounded
   task automatic wait_run(output int k);
      int lim;
      k = 0;
      lim = 0;
      while (sys_reset_n !== 1'b1 && lim < 2000)
      begin
         @(posedge mclk);
         #1;
         lim++;
         if (reset_pin_oe === 1'b1)
            k++;
      end
      `CHK(sys_reset_n, 1'b1)
   endtask

   task automatic wdg_reset();
      @(posedge mclk);
      wdg_underflow <= 1'b1;
      @(posedge mclk);
      wdg_underflow <= 1'b0;
      cyc(2);
      `CHK(sys_reset_n, 1'b0)
      wait_run(n);
      // the underflow edge and two more pass before counting
      `CHK(n >= `SI_RESET_DELAY_CYC + `SI_WDG_PULSE_CYC - 3, 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic power_on();
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      wait_run(n);
      `CHK(n >= `SI_RESET_DELAY_CYC, 1'b1)
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd, 8'h08)
      `CHK(threshold_sel, 2'b01)
      pll_locked <= 1'b0;
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd[`SI_BIT_LOCKED], 1'b0)
      pll_locked <= 1'b1;
   endtask

   task automatic reg_access();
      wr(`SI_CSR_ADDR, 8'h0f);
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd, 8'h09)
      rdreg(8'h3b, rd);
      `CHK(rd, 8'h00)
   endtask

   task automatic warning_irq();
      warn_cmp_below <= 1'b1;
      cyc(6);
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd[`SI_BIT_WARN_FLAG], 1'b1)
      `CHK(irq_req, 1'b1)
      global_irq_mask <= 1'b1;
      cyc(1);
      `CHK(irq_req, 1'b0)
      wait_mode <= 1'b1;
      cyc(1);
      `CHK(wake_from_wait, 1'b1)
      halt_mode <= 1'b1;
      cyc(1);
      `CHK(wake_from_wait, 1'b0)
      wr(`SI_CSR_ADDR, 8'h00);
      halt_mode <= 1'b0;
      wait_mode <= 1'b0;
      global_irq_mask <= 1'b0;
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd[`SI_BIT_IRQ_ENABLE], 1'b1)
      @(posedge mclk);
      irq_ack <= 1'b1;
      @(posedge mclk);
      irq_ack <= 1'b0;
      cyc(1);
      `CHK(irq_req, 1'b0)
      // falling edge of the flag must interrupt too
      warn_cmp_below <= 1'b0;
      cyc(6);
      `CHK(irq_req, 1'b1)
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd, 8'h09)
      irq_ack <= 1'b1;
      wr(`SI_CSR_ADDR, 8'h00);
      irq_ack <= 1'b0;
   endtask

   task automatic drop_reset();
      opt_threshold_sel <= 2'b10;
      clr_seen <= 1'b0;
      drop_cmp_below <= 1'b1;
      cyc(5);
      `CHK({reset_pin_oe, sys_reset_n}, 2'b10)
      // held well past any timed pulse: reset must stay static
      cyc(300);
      `CHK({reset_pin_oe, sys_reset_n}, 2'b10)
      `CHK(low_cycles > 0, 1'b1)
      `CHK(reset_pin_out, 1'b0)
      `CHK(clr_seen, 1'b1)
      drop_cmp_below <= 1'b0;
      wait_run(n);
      `CHK(n >= `SI_RESET_DELAY_CYC, 1'b1)
      `CHK(threshold_sel, 2'b10)
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd, 8'h0c)
   endtask

   task automatic other_resets();
      opt_threshold_sel <= 2'b11;
      wdg_reset();
      `CHK(threshold_sel, 2'b11)
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd[`SI_BIT_DROP_FLAG], 1'b1)
      cyc(5);
      ext_pull <= 1'b1;
      cyc(10);
      `CHK(sys_reset_n, 1'b0)
      ext_pull <= 1'b0;
      wait_run(n);
      // seven delay cycles elapse while the line is still pulled
      `CHK(n >= `SI_RESET_DELAY_CYC - 7, 1'b1)
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd[`SI_BIT_DROP_FLAG], 1'b1)
      wr(`SI_CSR_ADDR, 8'h00);
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd, 8'h08)
   endtask

   // option only taken during reset, so disable through a watchdog reset
   task automatic detector_off();
      opt_detector_enable <= 1'b0;
      wdg_reset();
      wr(`SI_CSR_ADDR, 8'h01);
      drop_cmp_below <= 1'b1;
      warn_cmp_below <= 1'b1;
      cyc(8);
      `CHK({reset_pin_oe, sys_reset_n}, 2'b01)
      rdreg(`SI_CSR_ADDR, rd);
      `CHK(rd[`SI_BIT_WARN_FLAG], 1'b0)
      `CHK(irq_req, 1'b0)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      power_on();
      reg_access();
      warning_irq();
      drop_reset();
      other_resets();
      detector_off();
      test_done();
   end
endmodule
